// ### include/pfb_pkg.sv
// package: constants, carriers and state layout of the program flow block
package pfb_pkg;
   localparam int PC_W = 13;                    // 8192-word program space
   localparam int PG_W = 10;                    // in-page address bits, 1024-word page
   localparam int SP_W = 3;                     // eight stack levels
   localparam int STK_N = 8;
   // register indices; the byte address is four times the index
   localparam logic [5:0] IDX_IND  = 6'h00;
   localparam logic [5:0] IDX_PC   = 6'h02;
   localparam logic [5:0] IDX_STAT = 6'h03;
   localparam logic [5:0] IDX_DPTR = 6'h04;
   localparam logic [5:0] IDX_SYS  = 6'h05;
   localparam logic [5:0] IDX_CTL  = 6'h06;
   // status word fields
   localparam int ST_BANK = 6;
   localparam int ST_T    = 4;
   localparam int ST_P    = 3;
   localparam int ST_Z    = 2;
   localparam int ST_DC   = 1;
   localparam int ST_C    = 0;
   localparam logic [7:0] ST_RST   = 8'h18;
   localparam logic [7:0] ST_WMASK = 8'hC7;
   // pointer and system control fields
   localparam int DP_GRP = 6;
   localparam logic [7:0] DP_RST   = 8'h00;
   localparam int SC_PG  = 4;
   localparam int SC_SIS = 1;
   localparam int SC_REM = 0;
   localparam logic [7:0] SC_RST   = 8'h04;
   localparam logic [7:0] SC_WMASK = 8'h33;
   localparam logic [7:0] SC_FIXED = 8'h04;
   // private control: bit 0 picks the four-clock instruction cycle
   localparam int CTL_LONG = 0;
   localparam logic [7:0] CTL_RST   = 8'h00;
   localparam logic [7:0] CTL_WMASK = 8'h01;
   // sys_clk edges per instruction cycle (fclk/2, fclk/4)
   localparam logic [3:0] CYC_SHORT = 4'h2;
   localparam logic [3:0] CYC_LONG  = 4'h4;
   // interrupt vectors, all in page 0
   localparam logic [PC_W-1:0] VEC_WDT  = 13'h0003;
   localparam logic [PC_W-1:0] VEC_INT0 = 13'h0006;
   localparam logic [PC_W-1:0] VEC_SPI  = 13'h0024;
   localparam logic [PC_W-1:0] VEC_TC4  = 13'h0027;
   localparam logic [PC_W-1:0] VEC_INT3 = 13'h002A;
   localparam logic [PC_W-1:0] VEC_ADC  = 13'h0030;
   localparam logic [PC_W-1:0] VEC_TC2  = 13'h0033;
   localparam logic [PC_W-1:0] VEC_INT5 = 13'h0036;

   typedef enum logic [3:0] {
      OP_SEQ = 4'h0, OP_BRANCH = 4'h1, OP_CALL = 4'h2, OP_RET = 4'h3, OP_LITERAL_STACK_POP_OP = 4'h4,
      OP_INTERRUPT_EXIT_OP = 4'h5, OP_PDOWN = 4'h6, OP_WATCHDOG_CLEAR_OP = 4'h7, OP_PCWR = 4'h8
   } pfb_opc_t;

   typedef enum logic [2:0] {
      SRC_WDT = 3'h0, SRC_INT0 = 3'h1, SRC_SPI = 3'h2, SRC_TC4 = 3'h3,
      SRC_INT3 = 3'h4, SRC_ADC = 3'h5, SRC_TC2 = 3'h6, SRC_INT5 = 3'h7
   } pfb_src_t;

   typedef enum logic [1:0] {
      FSM_RUN = 2'b00, FSM_BUSY = 2'b01, FSM_IDLE = 2'b10, FSM_SLEEP = 2'b11
   } pfb_fsm_t;

   typedef struct packed {
      pfb_opc_t          code;
      logic [PG_W-1:0]   operand;
   } pfb_op_t;

   typedef struct packed {
      logic valid;
      logic zero;
      logic aux;
      logic carry;
   } pfb_alu_t;

   typedef struct packed {
      pfb_fsm_t          fsm;
      logic [2:0]        cnt;
      logic [PC_W-1:0]   pc;
      logic [7:0]        stat;
      logic [7:0]        dptr;
      logic [7:0]        sysc;
      logic [7:0]        ctl;
      logic [SP_W-1:0]   sp;
      logic [7:0]        ctx_acc;
      logic [7:0]        ctx_stat;
      logic [1:0]        ctx_pg;
      logic [7:0]        acc_out;
      logic              acc_load;
      logic              irq_ack;
      logic              op_ready;
      logic              idle;
      logic              sleep;
      logic              wait_r;
      logic [31:0]       rdata;
      logic              wk_s1;
      logic              wk_s2;
      logic              wk_prev;
   } pfb_state_t;

   localparam pfb_state_t PFB_RST = '{fsm: FSM_RUN, op_ready: 1'b1, wait_r: 1'b1,
                                      stat: ST_RST, dptr: DP_RST, sysc: SC_RST,
                                      ctl: CTL_RST, default: '0};

   function automatic logic [PC_W-1:0] pfb_vector(input pfb_src_t src);
      unique case (src)
         SRC_WDT:  return VEC_WDT;
         SRC_INT0: return VEC_INT0;
         SRC_SPI:  return VEC_SPI;
         SRC_TC4:  return VEC_TC4;
         SRC_INT3: return VEC_INT3;
         SRC_ADC:  return VEC_ADC;
         SRC_TC2:  return VEC_TC2;
         SRC_INT5: return VEC_INT5;
      endcase
   endfunction
endpackage

// ### verilog/pfb_stack_mem.sv
// return stack storage: eight words, registered read port
`timescale 1ns/1ns
module pfb_stack_mem
   import pfb_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   input  wire logic               ce,
   input  wire logic               we,
   input  wire logic [SP_W-1:0]    waddr,
   input  wire logic [PC_W-1:0]    wdata,
   input  wire logic [SP_W-1:0]    raddr,
   output logic      [PC_W-1:0]    rdata_reg
);
   logic [PC_W-1:0] mem [STK_N];

   // storage has no reset; an empty stack pops whatever was left there
   always_ff @(posedge sys_clk) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
   end

   // read data registered so the top entry comes from a flip-flop
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else if (ce) begin
         rdata_reg <= mem[raddr];
      end
   end
endmodule // pfb_stack_mem

// ### verilog/pfb_core.sv
// program flow sequencer: counter, return stack, vectors, status and bank select
`timescale 1ns/1ns
// What this block does
// R1 - program counter and stack entries hold a 13-bit address, page bits included
// R2 - program space is 8192 words of 13 bits in 1024-word pages
// R3 - reset clears the program counter so execution starts at zero
// R4 - direct branch loads its operand into the low 10 counter bits
// R5 - subroutine jump loads low 10 bits and pushes the next address
// R6 - return, literal return and interrupt exit pop the stack into the counter
// R7 - one instruction cycle per op, one extra when the counter is changed
// R8 - interrupt jumps to a page 0 vector, saving and restoring context
// R9 - watchdog overflow vectors to 0003h, external pin zero to 0006h
// R10 - further vectors 0024h, 0027h, 002Ah, 0030h, 0033h, 0036h
// R11 - stack is eight levels, shared by calls and interrupts
// R12 - status bits 7:6 select one of four banks at 05H-0FH
// R13 - time-out bit set by power-up, power-down, watchdog clear; cleared on time-out
// R14 - power-down bit set at power-on and watchdog clear; cleared by power-down
// R15 - zero flag on zero result; aux carry in bit 1, carry in bit 0
// R16 - pointer bits 7:6 map general bank 0 to 3 into 20H-3FH
// R17 - six-bit pointer field selects indirect target, else plain storage
// R18 - branch, call or counter write copy page select into the counter
// R19 - returns leave page select untouched and go back to the calling page; interrupt exit here restores the saved page select
// R20 - page codes 00..11 map to 0000, 0400, 0800, 0C00 page bases
// R21 - system control bit 1 picks idle (0) or sleep (1)
// R22 - system control bit 0 picks wake on rising edge (0) or high level (1)
// R23 - index zero is no storage; it redirects through the pointer field
// R24 - every op that keeps the flow advances the counter by one
module pfb_core
   import pfb_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   input  wire logic               ce,
   input  wire logic               op_valid,
   input  wire pfb_op_t            op_in,
   output logic                    op_ready,
   input  wire logic               irq_req,
   input  wire pfb_src_t           irq_src,
   output logic                    irq_ack,
   input  wire pfb_alu_t           alu_in,
   input  wire logic               wdt_timeout,
   input  wire logic [7:0]         acc_in,
   input  wire logic               wake_pin,
   output logic      [PC_W-1:0]    prog_addr,
   output logic      [7:0]         acc_restore,
   output logic                    acc_restore_valid,
   output logic      [1:0]         special_group,
   output logic      [1:0]         data_group,
   output logic      [5:0]         indirect_ptr,
   output logic                    idle_mode,
   output logic                    sleep_mode,
   input  wire logic [4:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [3:0]         avs_byteenable,
   input  wire logic [31:0]        avs_writedata,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest
);
   pfb_state_t        r_reg;
   pfb_state_t        r_next;
   logic              fire;
   logic              take_irq;
   logic              wake_ok;
   logic              bus_wr;
   logic [5:0]        eff_idx;
   logic [1:0]        page;
   logic              stk_we;
   logic [PC_W-1:0]   stk_wdata;
   logic [SP_W-1:0]   stk_raddr;
   logic [PC_W-1:0]   stk_top;
   logic [PC_W-1:0]   jump_addr;

   // busy length after an accepted op, in sys_clk edges minus one
   function automatic logic [2:0] busy_count(input logic long_c, input logic flow);
      logic [3:0] len;
      len = long_c ? CYC_LONG : CYC_SHORT;
      if (flow) begin
         len = {len[2:0], 1'b0};
      end
      return len[2:0] - 3'h1;
   endfunction

   // software view of a register index
   function automatic logic [15:0] reg_value(input pfb_state_t s, input logic [5:0] idx);
      case (idx)
         IDX_PC:   reg_value = {3'h0, s.pc};
         IDX_STAT: reg_value = {8'h00, s.stat};
         IDX_DPTR: reg_value = {8'h00, s.dptr};
         IDX_SYS:  reg_value = {8'h00, s.sysc};
         IDX_CTL:  reg_value = {7'h00, s.fsm == FSM_SLEEP, s.ctl};
         default:  reg_value = 16'h0000;
      endcase
   endfunction

   // stack sits in its own memory; top entry is the word below the pointer
   assign stk_raddr = r_reg.sp - 3'h1;

   pfb_stack_mem u_stack (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .we        (stk_we),
      .waddr     (r_reg.sp),
      .wdata     (stk_wdata),
      .raddr     (stk_raddr),
      .rdata_reg (stk_top)
   );

   // next-state logic for bus slave, sequencer and status word
   always_comb begin
      r_next = r_reg;
      r_next.acc_load = 1'b0;
      r_next.irq_ack = 1'b0;
      fire = 1'b0;
      take_irq = 1'b0;
      stk_we = 1'b0;
      stk_wdata = r_reg.pc + 13'h0001;
      page = r_reg.sysc[SC_PG +: 2];
      jump_addr = {1'b0, page, op_in.operand}; // R18 R20 R4

      // wake pin crosses in through two flops; edge taken after the second
      r_next.wk_s1 = wake_pin;
      r_next.wk_s2 = r_reg.wk_s1;
      r_next.wk_prev = r_reg.wk_s2;
      wake_ok = r_reg.sysc[SC_REM] ? r_reg.wk_s2 : (r_reg.wk_s2 & ~r_reg.wk_prev); // R22

      // index zero goes through the pointer field
      eff_idx = (avs_address[4:2] == 3'h0) ? r_reg.dptr[5:0] : {3'h0, avs_address[4:2]}; // R23 R17

      // one wait state, then the answer; write lands with waitrequest low
      bus_wr = avs_write && !r_reg.wait_r && avs_byteenable[0];
      if ((avs_read || avs_write) && r_reg.wait_r) begin
         r_next.wait_r = 1'b0;
         if (avs_read) begin
            r_next.rdata = {16'h0000, reg_value(r_reg, eff_idx)};
         end
      end else begin
         r_next.wait_r = 1'b1;
      end
      if (bus_wr) begin
         case (eff_idx)
            IDX_PC:   r_next.pc = {1'b0, page, avs_writedata[PG_W-1:0]}; // R18
            IDX_STAT: r_next.stat = (r_reg.stat & ~ST_WMASK) | (avs_writedata[7:0] & ST_WMASK);
            IDX_DPTR: r_next.dptr = avs_writedata[7:0]; // R16 R17
            IDX_SYS:  r_next.sysc = (avs_writedata[7:0] & SC_WMASK) | SC_FIXED;
            IDX_CTL:  r_next.ctl = avs_writedata[7:0] & CTL_WMASK;
            default:  r_next.ctl = r_reg.ctl;
         endcase
      end

      // arithmetic flags follow the alu; they win over a bus write
      if (alu_in.valid) begin
         r_next.stat[ST_Z] = alu_in.zero; // R15
         r_next.stat[ST_DC] = alu_in.aux; // R15
         r_next.stat[ST_C] = alu_in.carry; // R15
      end

      unique case (r_reg.fsm)
         FSM_RUN: begin
            // interrupts are taken at an instruction boundary ahead of the op
            if (irq_req && r_reg.op_ready) begin
               take_irq = 1'b1;
               stk_we = 1'b1; // R11
               stk_wdata = r_reg.pc; // R8
               r_next.sp = r_reg.sp + 3'h1; // R11
               r_next.ctx_acc = acc_in; // R8
               r_next.ctx_stat = r_next.stat; // R8
               r_next.ctx_pg = page; // R8
               r_next.pc = pfb_vector(irq_src); // R8 R9 R10
               r_next.irq_ack = 1'b1;
               r_next.op_ready = 1'b0;
               r_next.fsm = FSM_BUSY;
               r_next.cnt = busy_count(r_reg.ctl[CTL_LONG], 1'b1); // R7
            end else if (op_valid && r_reg.op_ready) begin
               fire = 1'b1;
               r_next.op_ready = 1'b0;
               r_next.fsm = FSM_BUSY;
               r_next.cnt = busy_count(r_reg.ctl[CTL_LONG], 1'b0); // R7
               r_next.pc = r_reg.pc + 13'h0001; // R24
               case (op_in.code)
                  OP_BRANCH, OP_PCWR: begin
                     r_next.pc = jump_addr; // R4 R18
                     r_next.cnt = busy_count(r_reg.ctl[CTL_LONG], 1'b1); // R7
                  end
                  OP_CALL: begin
                     stk_we = 1'b1; // R5
                     r_next.sp = r_reg.sp + 3'h1; // R5 R11
                     r_next.pc = jump_addr; // R5 R18
                     r_next.cnt = busy_count(r_reg.ctl[CTL_LONG], 1'b1); // R7
                  end
                  OP_RET, OP_LITERAL_STACK_POP_OP, OP_INTERRUPT_EXIT_OP: begin
                     // the saved word holds its page, so page select is not used
                     r_next.pc = stk_top; // R6 R19
                     r_next.sp = r_reg.sp - 3'h1; // R6
                     r_next.cnt = busy_count(r_reg.ctl[CTL_LONG], 1'b1); // R7
                     if (op_in.code == OP_INTERRUPT_EXIT_OP) begin
                        r_next.stat = r_reg.ctx_stat; // R8
                        r_next.sysc[SC_PG +: 2] = r_reg.ctx_pg; // R8
                        r_next.acc_out = r_reg.ctx_acc; // R8
                        r_next.acc_load = 1'b1; // R8
                     end
                  end
                  OP_PDOWN: begin
                     r_next.stat[ST_T] = 1'b1; // R13
                     r_next.stat[ST_P] = 1'b0; // R14
                     r_next.fsm = r_reg.sysc[SC_SIS] ? FSM_SLEEP : FSM_IDLE; // R21
                     r_next.sleep = r_reg.sysc[SC_SIS]; // R21
                     r_next.idle = ~r_reg.sysc[SC_SIS]; // R21
                  end
                  OP_WATCHDOG_CLEAR_OP: begin
                     r_next.stat[ST_T] = 1'b1; // R13
                     r_next.stat[ST_P] = 1'b1; // R14
                  end
                  default: begin
                     r_next.pc = r_reg.pc + 13'h0001; // R24
                  end
               endcase
            end
         end
         FSM_BUSY: begin
            if (r_reg.cnt <= 3'h1) begin
               r_next.fsm = FSM_RUN;
               r_next.op_ready = 1'b1;
            end else begin
               r_next.cnt = r_reg.cnt - 3'h1;
            end
         end
         FSM_IDLE: begin
            // idle keeps clocks alive, so any interrupt or time-out ends it
            if (irq_req || wdt_timeout) begin
               r_next.fsm = FSM_RUN;
               r_next.op_ready = 1'b1;
               r_next.idle = 1'b0;
            end
         end
         FSM_SLEEP: begin
            if (wake_ok || wdt_timeout) begin
               r_next.fsm = FSM_RUN; // R22
               r_next.op_ready = 1'b1;
               r_next.sleep = 1'b0;
            end
         end
      endcase

      // time-out beats a same-cycle power-down or watchdog clear
      if (wdt_timeout) begin
         r_next.stat[ST_T] = 1'b0; // R13
      end
   end

   // reset brings the counter to zero and time-out, power-down bits to one
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         r_reg <= PFB_RST; // R3 R13 R14
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   // every output is a state field
   assign prog_addr         = r_reg.pc; // R1 R2
   assign op_ready          = r_reg.op_ready;
   assign irq_ack           = r_reg.irq_ack;
   assign acc_restore       = r_reg.acc_out;
   assign acc_restore_valid = r_reg.acc_load;
   assign special_group     = r_reg.stat[ST_BANK +: 2]; // R12
   assign data_group        = r_reg.dptr[DP_GRP +: 2]; // R16
   assign indirect_ptr      = r_reg.dptr[5:0]; // R17
   assign idle_mode         = r_reg.idle;
   assign sleep_mode        = r_reg.sleep;
   assign avs_readdata      = r_reg.rdata;
   assign avs_waitrequest   = r_reg.wait_r;

   // checks, active while the clock enable stays high
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n || !ce);

   sequence s_flow_short;
      fire && !r_reg.ctl[CTL_LONG] && (op_in.code == OP_BRANCH || op_in.code == OP_CALL);
   endsequence
   sequence s_seq_short;
      fire && !r_reg.ctl[CTL_LONG] && op_in.code == OP_SEQ;
   endsequence
   sequence s_pop;
      fire && (op_in.code == OP_RET || op_in.code == OP_LITERAL_STACK_POP_OP || op_in.code == OP_INTERRUPT_EXIT_OP);
   endsequence

   pc_reset_a: assert property ($rose(rst_n) |-> prog_addr == 13'h0000) // R3
      else $error("counter not zero after reset");
   seq_incr_a: assert property (s_seq_short |=> prog_addr == $past(prog_addr) + 13'h0001) // R24
      else $error("sequential op did not advance counter");
   branch_load_a: assert property (fire && op_in.code == OP_BRANCH |=>
                                    prog_addr == {1'b0, $past(page), $past(op_in.operand)}) // R4
      else $error("branch target wrong");
   call_push_a: assert property (fire && op_in.code == OP_CALL |=>
                                  r_reg.sp == $past(r_reg.sp) + 3'h1) // R5
      else $error("call did not push");
   ret_pop_a: assert property (s_pop |=> prog_addr == $past(stk_top)
                                ##0 r_reg.sp == $past(r_reg.sp) - 3'h1) // R6
      else $error("return did not pop");
   flow_stall_a: assert property (s_flow_short |=> !op_ready [*3] ##1 op_ready) // R7
      else $error("flow op length wrong");
   seq_stall_a: assert property (s_seq_short |=> !op_ready ##1 op_ready) // R7
      else $error("plain op length wrong");
   irq_vector_a: assert property (take_irq |=> prog_addr == pfb_vector($past(irq_src))
                                   && irq_ack) // R9
      else $error("interrupt vector wrong");
   ctx_restore_a: assert property (fire && op_in.code == OP_INTERRUPT_EXIT_OP |=> acc_restore_valid
                                    && acc_restore == $past(r_reg.ctx_acc)) // R8
      else $error("context not restored");
   tbit_clear_a: assert property (wdt_timeout |=> !r_reg.stat[ST_T]) // R13
      else $error("time-out bit not cleared");
   pbit_down_a: assert property (fire && op_in.code == OP_PDOWN && !wdt_timeout |=>
                                  !r_reg.stat[ST_P] && r_reg.stat[ST_T]) // R14
      else $error("power-down bits wrong");
   sleep_kind_a: assert property (fire && op_in.code == OP_PDOWN |=>
                                   sleep_mode == $past(r_reg.sysc[SC_SIS])
                                   && idle_mode != sleep_mode) // R21
      else $error("low-power kind wrong");
   zero_flag_a: assert property (alu_in.valid |=> r_reg.stat[ST_Z] == $past(alu_in.zero)) // R15
      else $error("zero flag not updated");
endmodule // pfb_core

// ### verif/pfb_dec_model.sv
// decoder stand-in: presents ops and holds each one until the core takes it
`timescale 1ns/1ns
module pfb_dec_model
   import pfb_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic op_ready,
   input  wire logic irq_req,
   output logic      op_valid,
   output pfb_op_t   op_in
);
   logic    [13:0] junk = 14'h2A5A;
   pfb_op_t        held = '0;
   initial op_valid = 1'b0;
   // idle bus toggles so a stale op is never mistaken for a new one
   always @(posedge sys_clk) junk <= ~junk;
   assign op_in = op_valid ? held : pfb_op_t'(junk);
   // hold the op until an edge with ready high and no interrupt pending
   task automatic issue(input pfb_opc_t c, input logic [PG_W-1:0] k);
      @(posedge sys_clk);
      op_valid <= 1'b1;
      held     <= '{code: c, operand: k};
      do @(posedge sys_clk); while (!(op_ready && !irq_req));
      op_valid <= 1'b0;
   endtask
endmodule // pfb_dec_model

// ### verif/pfb_core_tb.sv
// self-checking bench of the program flow core against an integer model
`timescale 1ns/1ns
module pfb_core_tb
   import pfb_pkg::*;
;
   logic        sys_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, irq_req = 1'b0;
   logic        wdt_timeout = 1'b0, wake_pin = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [4:0]  avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [7:0]  acc_in = 8'h00, acc_restore;
   pfb_alu_t    alu_in = '0;
   pfb_src_t    irq_src = SRC_WDT;
   pfb_op_t     op_in;
   logic        op_valid, op_ready, irq_ack, acc_restore_valid, idle_mode, sleep_mode;
   logic        avs_waitrequest;
   logic [12:0] prog_addr;
   logic [1:0]  special_group, data_group;
   logic [5:0]  indirect_ptr;
   logic [15:0] lf = 16'hE58F;
   int          miscompares = 0, tests_run = 0, pc, pg, stk[$];
   int          vec[8] = '{'h3, 'h6, 'h24, 'h27, 'h2A, 'h30, 'h33, 'h36};

   pfb_core i_dut (.sys_clk, .rst_n, .ce, .op_valid, .op_in, .op_ready, .irq_req, .irq_src,
      .irq_ack, .alu_in, .wdt_timeout, .acc_in, .wake_pin, .prog_addr, .acc_restore,
      .acc_restore_valid, .special_group, .data_group, .indirect_ptr, .idle_mode,
      .sleep_mode, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
      .avs_readdata, .avs_waitrequest);
   pfb_dec_model i_dec (.sys_clk, .op_ready, .irq_req, .op_valid, .op_in);

   // free-running core clock
   initial forever #5 sys_clk = ~sys_clk;

   function automatic logic [15:0] rnd(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // one bus cycle, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge sys_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= !wr;
      avs_write     <= wr;
      // no cycle limit here: only the watchdog may end a wait
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask

   task automatic wrdy(output int n);
      n = 0;
      do begin @(posedge sys_clk); n++; end while (op_ready !== 1'b1);
   endtask

   task automatic op(input pfb_opc_t c, input logic [9:0] k, input int l);
      int n;
      i_dec.issue(c, k);
      wrdy(n);
      chk(n, l);
      chk(prog_addr, pc);
   endtask

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (30000) @(posedge sys_clk);
      miscompares++;
      wrap_up;
   end

   // main sequence; pc, pg and stk model counter, page and return stack
   initial begin
      int n;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(5'h08, 0);
      rd(5'h0C, 32'h18);
      rd(5'h14, 32'h04);
      rd(5'h04, 0);
      pc = 1;
      op(OP_SEQ, 10'h0, 2);
      $display("test reset done");
      wr(5'h14, 32'h10);
      pg = 1;
      lf = rnd(lf);
      pc = pg * 1024 + lf[9:0];
      op(OP_BRANCH, lf[9:0], 4);
      stk.push_back(pc + 1);
      lf = rnd(lf);
      pc = pg * 1024 + lf[9:0];
      op(OP_CALL, lf[9:0], 4);
      wr(5'h14, 32'h20);
      pg = 2;
      pc = stk.pop_back();
      op(OP_RET, 10'h0, 4);
      rd(5'h14, 32'h24);
      lf = rnd(lf);
      pc = pg * 1024 + lf[9:0];
      op(OP_PCWR, lf[9:0], 4);
      wr(5'h08, 32'h155);
      pc = pg * 1024 + 'h155;
      rd(5'h08, pc);
      // long instruction cycle doubles every count
      wr(5'h18, 32'h1);
      pc = pc + 1;
      op(OP_SEQ, 10'h0, 4);
      stk.push_back(pc + 1);
      pc = pg * 1024 + 'h3FF;
      op(OP_CALL, 10'h3FF, 8);
      pc = stk.pop_back();
      op(OP_LITERAL_STACK_POP_OP, 10'h0, 8);
      wr(5'h18, 32'h0);
      $display("test flow done");
      for (int s = 0; s < 8; s++) begin
         lf = rnd(lf);
         acc_in  <= lf[7:0];
         irq_src <= pfb_src_t'(s);
         irq_req <= 1'b1;
         @(posedge sys_clk);
         irq_req <= 1'b0;
         @(posedge sys_clk);
         chk(irq_ack, 1'b1);
         chk(prog_addr, vec[s]);
         stk.push_back(pc);
         wrdy(n);
         wr(5'h0C, 32'hC0);
         wr(5'h14, 32'h00);
         pc = stk.pop_back();
         op(OP_INTERRUPT_EXIT_OP, 10'h0, 4);
         chk(acc_restore, lf[7:0]);
         rd(5'h0C, 32'h18);
         rd(5'h14, 32'h24);
      end
      $display("test interrupt done");
      for (int b = 0; b < 4; b++) begin
         lf = rnd(lf);
         wr(5'h0C, b << 6);
         wr(5'h10, lf[7:0]);
         @(posedge sys_clk);
         chk(special_group, b);
         chk(data_group, lf[7:6]);
         chk(indirect_ptr, lf[5:0]);
         rd(5'h10, lf[7:0]);
      end
      wr(5'h10, 32'h03);
      rd(5'h00, 32'hD8);
      lf = rnd(lf);
      alu_in <= {1'b1, lf[2:0]};
      @(posedge sys_clk);
      alu_in <= '0;
      rd(5'h0C, 32'hD8 | lf[2:0]);
      $display("test banks done");
      wr(5'h14, 32'h00);
      i_dec.issue(OP_PDOWN, 10'h0);
      repeat (3) @(posedge sys_clk);
      chk(idle_mode, 1'b1);
      wdt_timeout <= 1'b1;
      @(posedge sys_clk);
      wdt_timeout <= 1'b0;
      wrdy(n);
      rd(5'h0C, 32'hC0 | lf[2:0]);
      i_dec.issue(OP_WATCHDOG_CLEAR_OP, 10'h0);
      wrdy(n);
      rd(5'h0C, 32'hD8 | lf[2:0]);
      for (int m = 0; m < 2; m++) begin
         wr(5'h14, 2 + m);
         i_dec.issue(OP_PDOWN, 10'h0);
         repeat (4) @(posedge sys_clk);
         chk(sleep_mode, 1'b1);
         wake_pin <= 1'b1;
         wrdy(n);
         chk(sleep_mode, 1'b0);
         wake_pin <= 1'b0;
      end
      rd(5'h0C, 32'hD0 | lf[2:0]);
      // clock enable low must freeze the flags despite an alu update
      ce     <= 1'b0;
      alu_in <= 4'hF;
      @(posedge sys_clk);
      alu_in <= '0;
      ce     <= 1'b1;
      rd(5'h0C, 32'hD0 | lf[2:0]);
      $display("test power done");
      wrap_up;
   end
endmodule // pfb_core_tb
